// file: swt_pkg.sv
// shared constants and types for the single-wire sensor slot block
package swt_pkg;
  // time base
  localparam int CLK_MHZ = 100;
  // line timing, microseconds as printed, then clock cycles
  localparam int RST_LOW_US = 480;
  localparam int PRES_WAIT_US = 30;
  localparam int PRES_LOW_US = 120;
  localparam int WR_SAMPLE_US = 30;
  localparam int RD_HOLD_US = 15;
  localparam int RST_LOW_CYC = RST_LOW_US * CLK_MHZ;
  localparam int PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
  localparam int PRES_LOW_CYC = PRES_LOW_US * CLK_MHZ;
  localparam int WR_SAMPLE_CYC = WR_SAMPLE_US * CLK_MHZ;
  localparam int RD_HOLD_CYC = RD_HOLD_US * CLK_MHZ;
  // busy times, milliseconds as printed, then clock cycles
  localparam int CONV_MS = 750;
  localparam int COPY_MS = 10;
  localparam int CONV_CYC = CONV_MS * 1000 * CLK_MHZ;
  localparam int COPY_CYC = COPY_MS * 1000 * CLK_MHZ;

  // memory function codes
  localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
  localparam logic [7:0] CMD_READ_SP = 8'hbe;
  localparam logic [7:0] CMD_COPY_SP = 8'h48;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_RELOAD = 8'hb8;
  localparam logic [7:0] CMD_POWER = 8'hb4;

  // scratchpad layout
  localparam int SP_TRIG_FIRST = 2;
  localparam int SP_TRIG_NUM = 3;
  localparam int SP_LAST = 8;
  // nonvolatile contents at power-up
  localparam logic [7:0] NV_HIGH_ALARM_RST = 8'h4b;
  localparam logic [7:0] NV_LOW_ALARM_RST = 8'h46;
  localparam logic [7:0] NV_CONFIG_RST = 8'h7f;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TEMP = 8'h08;
  localparam logic [7:0] REG_AUX = 8'h0c;
  localparam logic [7:0] REG_TRIG = 8'h10;
  localparam logic [7:0] REG_NV = 8'h14;
  // control fields
  localparam int CTRL_EXT_POWER = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TEMP_RST = 32'h0000_0550;
  localparam logic [31:0] AUX_RST = 32'h0000_0000;
  // htrans codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // one cycle events from the slot timer to the command logic
  typedef struct packed {
    logic bus_reset;
    logic slot_start;
    logic rx_valid;
    logic rx_bit;
  } swt_slot_evt_t;

  // what the device answers in the next read slot
  typedef struct packed {
    logic en;
    logic bit_val;
  } swt_tx_t;
endpackage

// file: swt_busy_timer.sv
// one-shot busy timer for conversion and nonvolatile copy
`timescale 1ns/1ps
module swt_busy_timer import swt_pkg::*; #(
  parameter int unsigned CYCLES = 1000
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_ff;

  // a start while busy restarts the full time
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= CW'(CYCLES);
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

  assign busy = (cnt_ff != '0);
endmodule

// file: swt_slot_phy.sv
// line timing: reset detect, presence pulse, write sampling, read drive
`timescale 1ns/1ps
module swt_slot_phy import swt_pkg::*; #(
  parameter int RST_CYC = RST_LOW_CYC,
  parameter int PRES_CYC = PRES_LOW_CYC,
  parameter int US_CYC = CLK_MHZ
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic dq_in,
  input wire swt_tx_t tx,
  output swt_slot_evt_t evt,
  output logic dq_oe
);
  localparam int CMAX = (RST_CYC > PRES_CYC) ? RST_CYC : PRES_CYC;
  localparam int CW = $clog2(CMAX + 1);
  // slot points follow the time base so a bench can run a faster one
  localparam int WAIT_CYC = PRES_WAIT_US * US_CYC;
  localparam int SAMPLE_CYC = WR_SAMPLE_US * US_CYC;
  localparam int HOLD_CYC = RD_HOLD_US * US_CYC;
  typedef enum logic [2:0] {PH_IDLE, PH_LOW, PH_WAIT_RISE, PH_PRES_WAIT, PH_PRES_DRV} swt_ph_t;

  swt_ph_t st_ff;
  logic [CW-1:0] cnt_ff;
  logic dq_prev_ff;
  logic rd_drv_ff;
  logic pres_drv_ff;
  logic fall;

  assign fall = dq_prev_ff & ~dq_in;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dq_prev_ff <= 1'b1;
    end else begin
      dq_prev_ff <= dq_in;
    end
  end

  // slot state and low-time counter
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_ff <= PH_IDLE;
      cnt_ff <= '0;
    end else begin
      case (st_ff)
        PH_IDLE: begin
          cnt_ff <= CW'(1);
          if (fall) begin
            st_ff <= PH_LOW;
          end
        end
        PH_LOW: begin
          cnt_ff <= cnt_ff + CW'(1);
          if (cnt_ff == CW'(RST_CYC)) begin
            st_ff <= PH_WAIT_RISE;
          end else if (dq_in && cnt_ff >= CW'(SAMPLE_CYC)) begin
            st_ff <= PH_IDLE;
          end
        end
        PH_WAIT_RISE: begin
          cnt_ff <= CW'(1);
          if (dq_in) begin
            st_ff <= PH_PRES_WAIT;
          end
        end
        PH_PRES_WAIT: begin
          cnt_ff <= cnt_ff + CW'(1);
          if (cnt_ff == CW'(WAIT_CYC)) begin
            st_ff <= PH_PRES_DRV;
            cnt_ff <= CW'(1);
          end
        end
        PH_PRES_DRV: begin
          cnt_ff <= cnt_ff + CW'(1);
          if (cnt_ff == CW'(PRES_CYC)) begin
            st_ff <= PH_IDLE;
          end
        end
        default: st_ff <= PH_IDLE;
      endcase
    end
  end

  // read slot pull-down, held from the master's fall for the valid window
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_drv_ff <= 1'b0;
    end else if (st_ff == PH_IDLE && fall) begin
      rd_drv_ff <= tx.en & ~tx.bit_val;
    end else if (st_ff != PH_LOW || cnt_ff == CW'(HOLD_CYC)) begin
      rd_drv_ff <= 1'b0;
    end
  end

  // presence pull-down is the only low the device starts by itself
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pres_drv_ff <= 1'b0;
    end else begin
      pres_drv_ff <= (st_ff == PH_PRES_WAIT && cnt_ff == CW'(WAIT_CYC)) ||
                     (st_ff == PH_PRES_DRV && cnt_ff != CW'(PRES_CYC));
    end
  end

  assign dq_oe = rd_drv_ff | pres_drv_ff;

  // events; the write bit is taken at a fixed point inside 15..60 us
  always_comb begin
    evt.slot_start = (st_ff == PH_IDLE) && fall;
    evt.rx_valid = (st_ff == PH_LOW) && (cnt_ff == CW'(SAMPLE_CYC));
    evt.rx_bit = dq_in;
    evt.bus_reset = (st_ff == PH_LOW) && (cnt_ff == CW'(RST_CYC));
  end
endmodule

// file: swt_sensor_top.sv
// single-wire sensor memory command handling with an ahb-lite register port
// Notes on behaviour
// - presence low after rise, fixed wait first
// - only presence is started by the device
// - write scratchpad fills bytes 2 to 4
// - read scratchpad streams bytes 0 to 8
// - reset abandons a read at any point
// - copy scratchpad stores bytes 2 to 4
// - copy status reads 0 busy, 1 done
// - convert starts, read slots show busy
// - conversion lasts up to 750 ms
// - reload restores triggers, slots show conversion busy
// - triggers reloaded from nonvolatile at power-up
// - power query answers 1 with external supply
// - write bit sampled 15 to 60 us in
// - line low past 480 us means reset
// - reset and rom command precede memory commands
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module swt_sensor_top import swt_pkg::*; #(
  parameter int RST_CYC = RST_LOW_CYC,
  parameter int PRES_CYC = PRES_LOW_CYC,
  parameter int unsigned CONV_CYCLES = CONV_CYC,
  parameter int unsigned COPY_CYCLES = COPY_CYC,
  parameter int US_CYC = CLK_MHZ
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe
);
  typedef enum logic [2:0] {ST_IDLE, ST_ROM, ST_CMD, ST_WRITE, ST_READ, ST_STATUS} swt_state_t;
  typedef enum logic [1:0] {SEL_CONV, SEL_COPY, SEL_POWER} swt_sel_t;

  swt_state_t st_ff;
  swt_sel_t sel_ff;
  swt_slot_evt_t evt;
  swt_tx_t tx;
  logic [7:0] shift_ff;
  logic [2:0] bit_ff;
  logic [3:0] byte_ff;
  logic [7:0] last_cmd_ff;
  logic [7:0] trig_ff [0:SP_TRIG_NUM-1];
  logic [7:0] nv_ff [0:SP_TRIG_NUM-1];
  logic [31:0] ctrl_ff;
  logic [31:0] temp_ff;
  logic [31:0] aux_ff;
  logic [31:0] hrdata_ff;
  logic [7:0] waddr_ff;
  logic wpend_ff;
  logic [7:0] nxt_byte;
  logic byte_done;
  logic conv_start;
  logic copy_start;
  logic conv_busy;
  logic copy_busy;
  logic ext_power;
  logic do_copy;
  logic do_reload;
  logic ahb_take;
  logic [7:0] sp_byte;

  assign ext_power = ctrl_ff[CTRL_EXT_POWER];

  swt_slot_phy #(
    .RST_CYC(RST_CYC),
    .PRES_CYC(PRES_CYC),
    .US_CYC(US_CYC)
  ) u_phy (
    .mclk(mclk),
    .resetn(resetn),
    .dq_in(dq_in),
    .tx(tx),
    .evt(evt),
    .dq_oe(dq_oe)
  );

  swt_busy_timer #(
    .CYCLES(CONV_CYCLES)
  ) u_conv (
    .mclk(mclk),
    .resetn(resetn),
    .start(conv_start),
    .busy(conv_busy)
  );

  swt_busy_timer #(
    .CYCLES(COPY_CYCLES)
  ) u_copy (
    .mclk(mclk),
    .resetn(resetn),
    .start(copy_start),
    .busy(copy_busy)
  );

  // open drain: the pin is only ever pulled low
  assign dq_out = 1'b0;

  // incoming bits shift in from the top, so bit 0 arrives first
  assign nxt_byte = {evt.rx_bit, shift_ff[7:1]};
  assign byte_done = evt.rx_valid && (bit_ff == 3'h7) &&
                     (st_ff == ST_ROM || st_ff == ST_CMD || st_ff == ST_WRITE);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      shift_ff <= 8'h00;
    end else if (evt.rx_valid) begin
      shift_ff <= nxt_byte;
    end
  end

  // command decode strobes
  assign conv_start = byte_done && st_ff == ST_CMD && nxt_byte == CMD_CONVERT;
  assign do_copy = byte_done && st_ff == ST_CMD && nxt_byte == CMD_COPY_SP;
  assign copy_start = do_copy;
  assign do_reload = byte_done && st_ff == ST_CMD && nxt_byte == CMD_RELOAD;

  // transaction sequencing; a bus reset wins over any command in flight
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_ff <= ST_IDLE;
      sel_ff <= SEL_CONV;
      bit_ff <= 3'h0;
      byte_ff <= 4'h0;
      last_cmd_ff <= 8'h00;
    end else if (evt.bus_reset) begin
      st_ff <= ST_ROM;
      bit_ff <= 3'h0;
      byte_ff <= 4'h0;
    end else begin
      case (st_ff)
        ST_ROM: begin
          if (evt.rx_valid) begin
            bit_ff <= bit_ff + 3'h1;
          end
          if (byte_done) begin
            st_ff <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (evt.rx_valid) begin
            bit_ff <= bit_ff + 3'h1;
          end
          if (byte_done) begin
            last_cmd_ff <= nxt_byte;
            byte_ff <= 4'h0;
            case (nxt_byte)
              CMD_WRITE_SP: st_ff <= ST_WRITE;
              CMD_READ_SP: st_ff <= ST_READ;
              CMD_COPY_SP: begin
                st_ff <= ST_STATUS;
                sel_ff <= SEL_COPY;
              end
              CMD_CONVERT, CMD_RELOAD: begin
                st_ff <= ST_STATUS;
                sel_ff <= SEL_CONV;
              end
              CMD_POWER: begin
                st_ff <= ST_STATUS;
                sel_ff <= SEL_POWER;
              end
              default: st_ff <= ST_IDLE;
            endcase
          end
        end
        ST_WRITE: begin
          if (evt.rx_valid) begin
            bit_ff <= bit_ff + 3'h1;
          end
          if (byte_done) begin
            byte_ff <= byte_ff + 4'h1;
            if (byte_ff == 4'(SP_TRIG_NUM - 1)) begin
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_READ: begin
          if (evt.slot_start) begin
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              byte_ff <= byte_ff + 4'h1;
              if (byte_ff == 4'(SP_LAST)) begin
                st_ff <= ST_IDLE;
              end
            end
          end
        end
        ST_STATUS: st_ff <= ST_STATUS;
        ST_IDLE: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // trigger and config bytes, scratchpad and nonvolatile copies
  for (genvar i = 0; i < SP_TRIG_NUM; i++) begin : g_trig
    localparam logic [7:0] NV_RST = (i == 0) ? NV_HIGH_ALARM_RST :
                                    (i == 1) ? NV_LOW_ALARM_RST : NV_CONFIG_RST;
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        trig_ff[i] <= NV_RST;
      end else if (byte_done && st_ff == ST_WRITE && byte_ff == 4'(i)) begin
        trig_ff[i] <= nxt_byte;
      end else if (do_reload) begin
        trig_ff[i] <= nv_ff[i];
      end
    end
    // contents survive bus resets; only power-up restores the defaults
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        nv_ff[i] <= NV_RST;
      end else if (do_copy) begin
        nv_ff[i] <= trig_ff[i];
      end
    end
  end

  // scratchpad view: temperature, triggers and four software bytes
  always_comb begin
    case (byte_ff)
      4'h0: sp_byte = temp_ff[7:0];
      4'h1: sp_byte = temp_ff[15:8];
      4'h2: sp_byte = trig_ff[0];
      4'h3: sp_byte = trig_ff[1];
      4'h4: sp_byte = trig_ff[2];
      4'h5: sp_byte = aux_ff[7:0];
      4'h6: sp_byte = aux_ff[15:8];
      4'h7: sp_byte = aux_ff[23:16];
      4'h8: sp_byte = aux_ff[31:24];
      default: sp_byte = 8'hff;
    endcase
  end

  // answer for the next read slot; outside these states the line reads 1
  always_comb begin
    tx.en = 1'b0;
    tx.bit_val = 1'b1;
    if (st_ff == ST_READ) begin
      tx.en = 1'b1;
      tx.bit_val = sp_byte[bit_ff];
    end else if (st_ff == ST_STATUS) begin
      tx.en = 1'b1;
      case (sel_ff)
        SEL_COPY: tx.bit_val = ~copy_busy;
        SEL_CONV: tx.bit_val = ~conv_busy;
        SEL_POWER: tx.bit_val = ext_power;
        default: tx.bit_val = 1'b1;
      endcase
    end
  end

  // ahb-lite slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign ahb_take = hsel && hready && htrans[1];

  // write address is held for the data phase
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wpend_ff <= 1'b0;
      waddr_ff <= 8'h00;
    end else begin
      wpend_ff <= ahb_take && hwrite;
      if (ahb_take) begin
        waddr_ff <= haddr[7:0];
      end
    end
  end

  // software registers; writes to read-only or unmapped words are dropped
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_ff <= CTRL_RST;
      temp_ff <= TEMP_RST;
      aux_ff <= AUX_RST;
    end else if (wpend_ff) begin
      case (waddr_ff)
        REG_CTRL: ctrl_ff <= {31'h0, hwdata[CTRL_EXT_POWER]};
        REG_TEMP: temp_ff <= {16'h0, hwdata[15:0]};
        REG_AUX: aux_ff <= hwdata;
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // read data is looked up at the address phase so the data phase needs no wait
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hrdata_ff <= 32'h0;
    end else if (ahb_take && !hwrite) begin
      case (haddr[7:0])
        REG_CTRL: hrdata_ff <= ctrl_ff;
        REG_STATUS: hrdata_ff <= {16'h0, last_cmd_ff, 1'b0, 2'(sel_ff),
                                  3'(st_ff), copy_busy, conv_busy};
        REG_TEMP: hrdata_ff <= temp_ff;
        REG_AUX: hrdata_ff <= aux_ff;
        REG_TRIG: hrdata_ff <= {8'h0, trig_ff[2], trig_ff[1], trig_ff[0]};
        REG_NV: hrdata_ff <= {8'h0, nv_ff[2], nv_ff[1], nv_ff[0]};
        default: hrdata_ff <= 32'h0;
      endcase
    end
  end
endmodule

// file: swt_sensor_properties.sv
// concurrent checks on the sensor block's register and line ports
`timescale 1ns/1ps
module swt_sensor_properties import swt_pkg::*; #(
  parameter int RST_CYC = RST_LOW_CYC,
  parameter int PRES_CYC = PRES_LOW_CYC,
  parameter int US_CYC = CLK_MHZ
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe
);
  logic [15:0] low_cnt_ff;
  logic [15:0] high_cnt_ff;
  logic [15:0] oe_cnt_ff;
  logic rst_seen_ff;
  // rule windows in cycles of the time base in use
  localparam logic [15:0] WAIT_LO = 16'(15 * US_CYC);
  localparam logic [15:0] WAIT_HI = 16'(60 * US_CYC);
  localparam logic [15:0] HOLD_LO = 16'(14 * US_CYC);
  localparam logic [15:0] HOLD_HI = 16'(15 * US_CYC);

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // low run from any driver; a read pull at a reset's start must not hide it
  always_ff @(posedge mclk) begin
    if (!resetn || dq_in) low_cnt_ff <= 16'h0;
    else if (low_cnt_ff != 16'hffff) low_cnt_ff <= low_cnt_ff + 16'h1;
  end
  // idle-high run before a drive starts
  always_ff @(posedge mclk) begin
    if (!resetn || !dq_in) high_cnt_ff <= 16'h0;
    else if (high_cnt_ff != 16'hffff) high_cnt_ff <= high_cnt_ff + 16'h1;
  end
  // length of our own pull-down
  always_ff @(posedge mclk) begin
    if (!resetn || !dq_oe) oe_cnt_ff <= 16'h0;
    else oe_cnt_ff <= oe_cnt_ff + 16'h1;
  end
  // reset seen and not yet answered
  always_ff @(posedge mclk) begin
    if (!resetn) rst_seen_ff <= 1'b0;
    else if (low_cnt_ff > RST_CYC) rst_seen_ff <= 1'b1;
    else if ($fell(dq_oe)) rst_seen_ff <= 1'b0;
  end

  AST_PRES_WAIT: assert property (
    $rose(dq_oe) && rst_seen_ff |-> high_cnt_ff inside {[WAIT_LO:WAIT_HI]})
    else $error("presence started outside its wait window");
  AST_PRES_LEN: assert property (
    $fell(dq_oe) && rst_seen_ff |-> oe_cnt_ff == PRES_CYC)
    else $error("presence pulse has the wrong length");
  AST_RESET_ANSWER: assert property (
    rst_seen_ff && dq_in |-> high_cnt_ff <= WAIT_HI)
    else $error("long low was not answered by presence");
  AST_ONLY_PRESENCE: assert property (
    $rose(dq_oe) |-> !$past(dq_in) || rst_seen_ff)
    else $error("device started a drive on an idle line");
  AST_READ_EDGE: assert property (
    $rose(dq_oe) && !$past(dq_in) |-> $past(dq_in, 2))
    else $error("read drive not launched right after the fall");
  AST_READ_HOLD: assert property (
    $fell(dq_oe) && !rst_seen_ff |-> oe_cnt_ff inside {[HOLD_LO:HOLD_HI]})
    else $error("read zero drive has the wrong length");
  AST_OPEN_DRAIN: assert property (
    dq_out == 1'b0)
    else $error("data pin driven high");
  AST_AHB_OKAY: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  AST_HRDATA_HOLD: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
endmodule

bind swt_sensor_top swt_sensor_properties #(.RST_CYC(RST_CYC), .PRES_CYC(PRES_CYC),
  .US_CYC(US_CYC))
  swt_sensor_properties_inst (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe(dq_oe));

// file: swt_wire_master.sv
// behavioural single-wire bus master for the sensor bench
`timescale 1ns/1ps
module swt_wire_master #(
  parameter int RST_LOW = 48100,
  parameter int US = 100
) (
  input wire logic mclk,
  input wire logic line,
  output logic m_oe
);
  initial m_oe = 1'b0;

  // one slot: short low sends 1 or opens a read, long low sends 0
  task automatic slot(input logic b, output logic s);
    for (int i = 0; i < 62 * US; i++) begin
      if (i == 0) m_oe <= 1'b1;
      if (i == (b ? 2 * US : 60 * US)) m_oe <= 1'b0;
      if (i == 10 * US) s = line;
      @(posedge mclk);
    end
  endtask

  task automatic put_byte(input logic [7:0] v);
    logic s;
    for (int k = 0; k < 8; k++) slot(v[k], s);
  endtask

  task automatic get_byte(output logic [7:0] v);
    for (int k = 0; k < 8; k++) slot(1'b1, v[k]);
  endtask

  // reset pulse, then listen long enough for any presence answer
  task automatic line_reset(output logic p);
    p = 1'b0;
    for (int i = 0; i < RST_LOW + 120 * US; i++) begin
      if (i == 0) m_oe <= 1'b1;
      if (i == RST_LOW) m_oe <= 1'b0;
      if (i > RST_LOW && !line) p = 1'b1;
      @(posedge mclk);
    end
  endtask
endmodule

// file: swt_sensor_top_tb_top.sv
// self-checking bench for the single-wire sensor block
`timescale 1ns/1ps
module swt_sensor_top_tb_top import swt_pkg::*;;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, dq_out, dq_oe, m_oe, line;
  logic [31:0] hrdata;
  logic [31:0] got_val;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int total_checks = 0;
  event got;

  // open-drain line with pullup: low while anyone pulls
  assign line = ~(dq_oe | m_oe);

  // four cycles per microsecond and short busy times keep the run bounded
  swt_sensor_top #(.RST_CYC(1920), .PRES_CYC(240), .CONV_CYCLES(300), .COPY_CYCLES(300),
    .US_CYC(4)) swt_sensor_top_inst (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dq_in(line), .dq_out(dq_out),
    .dq_oe(dq_oe));
  swt_wire_master #(.RST_LOW(1940), .US(4)) swt_wire_master_inst (.mclk(mclk), .line(line),
    .m_oe(m_oe));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic result(input logic [31:0] v);
    got_val = v;
    -> got;
  endtask

  // watcher pairs every result with the oldest note
  initial begin
    forever begin
      @(got);
      if (exp_q.size() == 0) check(got_val, ~got_val);
      else check(got_val, exp_q.pop_front());
    end
  end

  // single transfer; trailing idle cycle keeps a read off a write's data phase
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    if (!w) result(hrdata);
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(a, 1'b0, 32'h0);
  endtask

  task automatic open_cmd(input logic [7:0] cmd);
    logic p;
    swt_wire_master_inst.line_reset(p);
    exp_q.push_back(32'h1);
    result({31'h0, p});
    swt_wire_master_inst.put_byte(8'($urandom));
    swt_wire_master_inst.put_byte(cmd);
  endtask

  task automatic get_exp(input logic [7:0] e);
    logic [7:0] v;
    exp_q.push_back({24'h0, e});
    swt_wire_master_inst.get_byte(v);
    result({24'h0, v});
  endtask

  task automatic bit_exp(input logic e);
    logic s;
    exp_q.push_back({31'h0, e});
    swt_wire_master_inst.slot(1'b1, s);
    result({31'h0, s});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    logic [7:0] b [3];
    void'($urandom(32'h74fe));
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(REG_TRIG, {8'h0, NV_CONFIG_RST, NV_LOW_ALARM_RST, NV_HIGH_ALARM_RST});
    rd(REG_TEMP, TEMP_RST);
    rd(8'h40, 32'h0);
    ahb(REG_TRIG, 1'b1, $urandom);
    rd(REG_TRIG, {8'h0, NV_CONFIG_RST, NV_LOW_ALARM_RST, NV_HIGH_ALARM_RST});
    $display("test registers done");
    // scratchpad write with random triggers, then a read cut short
    open_cmd(CMD_WRITE_SP);
    foreach (b[i]) begin
      b[i] = 8'($urandom);
      swt_wire_master_inst.put_byte(b[i]);
    end
    rd(REG_TRIG, {8'h0, b[2], b[1], b[0]});
    open_cmd(CMD_READ_SP);
    get_exp(TEMP_RST[7:0]);
    get_exp(TEMP_RST[15:8]);
    get_exp(b[0]);
    open_cmd(CMD_READ_SP);
    get_exp(TEMP_RST[7:0]);
    $display("test scratchpad done");
    // copy and conversion both report busy, then done
    ahb(REG_CTRL, 1'b1, 32'h1);
    open_cmd(CMD_COPY_SP);
    bit_exp(1'b0);
    bit_exp(1'b1);
    rd(REG_NV, {8'h0, b[2], b[1], b[0]});
    open_cmd(CMD_CONVERT);
    bit_exp(1'b0);
    bit_exp(1'b1);
    $display("test busy done");
    // overwrite triggers, then restore them from nonvolatile storage
    open_cmd(CMD_WRITE_SP);
    for (int i = 0; i < 3; i++) swt_wire_master_inst.put_byte(~b[i]);
    open_cmd(CMD_RELOAD);
    bit_exp(1'b1);
    rd(REG_TRIG, {8'h0, b[2], b[1], b[0]});
    // supply mode in both settings
    for (int e = 0; e < 2; e++) begin
      ahb(REG_CTRL, 1'b1, 32'(e));
      open_cmd(CMD_POWER);
      bit_exp(e[0]);
      bit_exp(e[0]);
    end
    $display("test reload and power done");
    complete_run();
  end

  // watchdog well past the expected run length
  initial begin
    repeat (120000) @(posedge mclk);
    miscompares++;
    complete_run();
  end
endmodule
